/* logic/clh_defs.vh */
// constants for the lookup coprocessor host port
`ifndef CLH_DEFS_VH
`define CLH_DEFS_VH

`define CLH_DQ_W 32
`define CLH_WORD_W 64
`define CLH_AC_W 13
`define CLH_PAGE_W 4
`define CLH_KIND_W 2
`define CLH_INSTR_W 12

`define CLH_DQ_LO_MSB 31
`define CLH_DQ_HI_MSB 63
`define CLH_DQ_HI_LSB 32
`define CLH_INSTR_MSB 11

`define CLH_KIND_CMP 2'h0
`define CLH_KIND_NFREE 2'h1
`define CLH_KIND_RAND 2'h2
`define CLH_KIND_NONE 2'h3

`define CLH_IDX_ONES 13'h1fff
`define CLH_IDX_RST 13'h0000
`define CLH_PAGE_RST 4'h0
`define CLH_DQ_RST 32'h00000000
`define CLH_CODE_RST 13'h0000
`define CLH_INSTR_PAD 1'h0

`define CLH_HOLD_W 20
`define CLH_HOLD_DRV 17
`define CLH_HOLD_MULTI 18
`define CLH_HOLD_HIT 19

`endif

/* logic/clh_hold_reg.v */
// result holder: follows its input only while the cycle strobe is high
`timescale 1ns/100ps
module clh_hold_reg #(
   parameter W = 8,
   parameter [W-1:0] RST = {W{1'b0}}
) (
   // clock and reset
   input wire clk,
   input wire sys_rst,
   // control
   input wire openGate,
   // data
   input wire [W-1:0] d,
   output reg [W-1:0] q
);

   always @(posedge clk) begin
      if (sys_rst) begin
         q <= RST;
      end else if (openGate) begin
         q <= d;
      end
   end

endmodule

/* logic/clh_host_port.v */
// strobe-synchronous host port of the lookup coprocessor
//
// Functional notes
// (R1) strobe high: data lines float, chip treated as disabled.
// (R2) direction low means controller writes, high means device drives data.
// (R3) strobe falling edge captures direction, selects, valid, bus, half, data.
// (R4) controller presents write data before the strobe falling edge.
// (R5) hardware control: address-valid low gives address, high a control code.
// (R6) software control: address/control bus ignored entirely.
// (R7) software control: address-valid high means instruction on low twelve bits.
// (R8) half select picks bits 31..0 when low, 63..32 when high.
// (R9) controller keeps half select low for 32-bit registers.
// (R10) either active-low chip select low at strobe fall selects device.
// (R11) chip selects never affect the index output bus.
// (R12) direction qualifies the control code and half select.
// (R13) active index shows match, next free or random address by cycle type.
// (R14) output enable high floats index outputs; low drives last result.
// (R15) cascade: only highest-priority responder drives, and only with enable low.
// (R16) no match or full system: lowest-priority device drives all ones.
// (R17) index outputs hold while strobe low, update only while high.
// (R18) page outputs carry configured page, latched like active index.
// (R19) page drives together with and like the active index.
// (R20) new entry write marks valid and drives the written index.
// (R21) delete clears validity and drives the deleted index.
// (R22) validity line: write low sets valid, high empty; read drives it.
// (R23) hit flag low on own match with chain high, or chain low.
// (R24) full flag low only when all valid and full chain low.
// (R25) multi-hit pulls low on two hits, or one hit when chain low.
// (R26) data lines driven only in a selected read while strobe low.
`timescale 1ns/100ps
`include "clh_defs.vh"
module clh_host_port (
   // clock and reset
   input wire clk,
   input wire sys_rst,
   // host strobe and control pins
   input wire strobeN,
   input wire selectOneN,
   input wire selectTwoN,
   input wire writeN,
   input wire addrValidN,
   input wire [`CLH_AC_W-1:0] addrCtlBus,
   input wire wordHalfSelect,
   input wire outEnableN,
   // host data lines
   input wire [`CLH_DQ_W-1:0] hostDataIn,
   output wire [`CLH_DQ_W-1:0] hostDataOut,
   output wire hostDataOe,
   // validity line
   input wire entryValidIn,
   output wire entryValidOut,
   output wire entryValidOe,
   // cascade chain
   input wire hitChainInN,
   input wire fullChainInN,
   output wire hitFlagN,
   output wire tableFullN,
   output wire multiHitOut,
   output wire multiHitOe,
   // index outputs to associated-data ram
   output wire [`CLH_AC_W-1:0] activeIndexOut,
   output wire activeIndexOe,
   output wire [`CLH_PAGE_W-1:0] pageIndexOut,
   output wire pageIndexOe,
   // configuration
   input wire swControl,
   input wire [`CLH_PAGE_W-1:0] pageConfig,
   input wire lowestPriority,
   // request to the array core
   output reg cmdStrobe_r,
   output reg cmdWrite_r,
   output reg cmdSelected_r,
   output reg cmdIsAddr_r,
   output reg cmdIsInstr_r,
   output reg [`CLH_AC_W-1:0] cmdCode_r,
   output reg cmdHalf_r,
   output reg [`CLH_DQ_W-1:0] cmdData_r,
   output reg cmdValidN_r,
   // answer from the array core
   input wire coreRdValid,
   input wire [`CLH_WORD_W-1:0] coreRdWord,
   input wire coreRdEntryValidN,
   input wire coreResValid,
   input wire [`CLH_KIND_W-1:0] coreResKind,
   input wire [`CLH_AC_W-1:0] coreResIndex,
   input wire coreHit,
   input wire coreMulti,
   input wire coreAllValid
);

   localparam [2:0] ST_IDLE = 3'b001;
   localparam [2:0] ST_ACT = 3'b010;
   localparam [2:0] ST_END = 3'b100;

   reg [2:0] state_r;
   reg [2:0] state_nxt;
   reg strobePrev_r;
   reg capWriteN_r;
   reg capSel_r;
   reg capAvN_r;
   reg [`CLH_AC_W-1:0] capAc_r;
   reg capHalf_r;
   reg [`CLH_DQ_W-1:0] capData_r;
   reg capValidN_r;
   reg capSw_r;
   reg [`CLH_DQ_W-1:0] rdData_r;
   reg rdValidN_r;
   reg [`CLH_AC_W-1:0] pendIdx_r;
   reg pendDrive_r;
   reg pendHit_r;
   reg pendMulti_r;
   reg firstLow_r;
   reg tableFullN_r;
   reg [`CLH_AC_W-1:0] codeSel;
   reg selNow;
   reg [`CLH_AC_W-1:0] resIdx;
   reg resDrive;

   wire strobeFall;
   wire strobeRise;
   wire [`CLH_HOLD_W-1:0] holdIdxD;
   wire [`CLH_HOLD_W-1:0] holdIdxQ;
   wire heldDrive;
   wire heldHit;
   wire heldMulti;
   wire readCycle;

   assign strobeFall = strobePrev_r & ~strobeN;
   assign strobeRise = ~strobePrev_r & strobeN;

   always @(posedge clk) begin
      if (sys_rst) begin
         strobePrev_r <= 1'b1;
      end else begin
         strobePrev_r <= strobeN;
      end
   end

   // cycle tracking, entered on strobe fall and left on rise
   always @* begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (strobeFall) begin
               state_nxt = ST_ACT;
            end
         end
         ST_ACT: begin
            if (strobeRise) begin
               state_nxt = ST_END;
            end
         end
         ST_END: begin
            if (strobeFall) begin
               state_nxt = ST_ACT;
            end else begin
               state_nxt = ST_IDLE;
            end
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   always @(posedge clk) begin
      if (sys_rst) begin
         state_r <= ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // (R10) select decode
   always @* begin
      selNow = ~selectOneN | ~selectTwoN;
   end

   // (R3) capture on strobe fall
   always @(posedge clk) begin
      if (sys_rst) begin
         capWriteN_r <= 1'b1;
         capSel_r <= 1'b0;
         capAvN_r <= 1'b1;
         capAc_r <= `CLH_CODE_RST;
         capHalf_r <= 1'b0;
         capData_r <= `CLH_DQ_RST;
         capValidN_r <= 1'b1;
         capSw_r <= 1'b0;
      end else if (strobeFall) begin
         capWriteN_r <= writeN;
         capSel_r <= selNow;
         capAvN_r <= addrValidN;
         capAc_r <= addrCtlBus;
         capHalf_r <= wordHalfSelect;
         capSw_r <= swControl;
         // (R22) validity and data sampled only for writes
         if (!writeN) begin
            capData_r <= hostDataIn;
            capValidN_r <= entryValidIn;
         end
      end
   end

   // (R5) address versus code under hardware control
   // (R6) bus unused under software control
   always @* begin
      if (capSw_r) begin
         // (R7) instruction rides on the low data bits
         if (capAvN_r) begin
            codeSel = {`CLH_INSTR_PAD, capData_r[`CLH_INSTR_MSB:0]};
         end else begin
            codeSel = `CLH_CODE_RST;
         end
      end else begin
         codeSel = capAc_r;
      end
   end

   // request issued the cycle after capture; (R12) direction travels with code
   always @(posedge clk) begin
      if (sys_rst) begin
         cmdStrobe_r <= 1'b0;
         cmdWrite_r <= 1'b0;
         cmdSelected_r <= 1'b0;
         cmdIsAddr_r <= 1'b0;
         cmdIsInstr_r <= 1'b0;
         cmdCode_r <= `CLH_CODE_RST;
         cmdHalf_r <= 1'b0;
         cmdData_r <= `CLH_DQ_RST;
         cmdValidN_r <= 1'b1;
      end else begin
         cmdStrobe_r <= (state_r == ST_ACT) & strobePrev_r == 1'b0 &
            ~cmdStrobe_r & (state_nxt == ST_ACT) & firstLow_r;
         cmdWrite_r <= ~capWriteN_r;
         cmdSelected_r <= capSel_r;
         cmdIsAddr_r <= ~capSw_r & ~capAvN_r;
         cmdIsInstr_r <= capSw_r & capAvN_r;
         cmdCode_r <= codeSel;
         // (R8) half select forwarded with the access
         cmdHalf_r <= capHalf_r;
         cmdData_r <= capData_r;
         cmdValidN_r <= capValidN_r;
      end
   end

   // marks the first cycle after the fall so one request leaves per cycle
   always @(posedge clk) begin
      if (sys_rst) begin
         firstLow_r <= 1'b0;
      end else begin
         firstLow_r <= strobeFall;
      end
   end

   // (R8) read data half picked by the captured half select
   always @(posedge clk) begin
      if (sys_rst) begin
         rdData_r <= `CLH_DQ_RST;
         rdValidN_r <= 1'b1;
      end else if (coreRdValid) begin
         if (capHalf_r) begin
            rdData_r <= coreRdWord[`CLH_DQ_HI_MSB:`CLH_DQ_HI_LSB];
         end else begin
            rdData_r <= coreRdWord[`CLH_DQ_LO_MSB:0];
         end
         rdValidN_r <= coreRdEntryValidN;
      end
   end

   // (R1) (R2) (R26) drive only in a selected read with strobe low
   assign readCycle = (state_r == ST_ACT) & ~strobeN & capWriteN_r &
      capSel_r;
   assign hostDataOut = rdData_r;
   assign hostDataOe = readCycle;
   // (R22) validity read back beside the data
   assign entryValidOut = rdValidN_r;
   assign entryValidOe = readCycle & ~capSw_r & ~capAvN_r;

   // (R13) (R15) (R16) responder and index choice per result kind
   // (R11) selects take no part here
   always @* begin
      resIdx = coreResIndex;
      resDrive = 1'b0;
      case (coreResKind)
         `CLH_KIND_CMP: begin
            resDrive = hitChainInN & (coreHit | lowestPriority);
            if (!coreHit) begin
               resIdx = `CLH_IDX_ONES;
            end
         end
         `CLH_KIND_NFREE: begin
            resDrive = ~fullChainInN & (~coreAllValid | lowestPriority);
            if (coreAllValid) begin
               resIdx = `CLH_IDX_ONES;
            end
         end
         // (R20) (R21) written or deleted index shown
         `CLH_KIND_RAND: begin
            resDrive = 1'b1;
         end
         default: begin
            resDrive = pendDrive_r;
            resIdx = pendIdx_r;
         end
      endcase
   end

   // (R23) (R25) compare results kept pending until the strobe rises
   always @(posedge clk) begin
      if (sys_rst) begin
         pendIdx_r <= `CLH_IDX_RST;
         pendDrive_r <= 1'b0;
         pendHit_r <= 1'b0;
         pendMulti_r <= 1'b0;
      end else if (coreResValid) begin
         pendIdx_r <= resIdx;
         pendDrive_r <= resDrive;
         if (coreResKind == `CLH_KIND_CMP) begin
            pendHit_r <= coreHit;
            pendMulti_r <= coreMulti;
         end
      end
   end

   // (R17) (R18) (R19) index, page and flags pass only while strobe high
   // flags share the latch, so they too change only after the rise
   assign holdIdxD = {pendHit_r, pendMulti_r, pendDrive_r, pageConfig,
      pendIdx_r};
   clh_hold_reg #(
      .W(`CLH_HOLD_W)
   ) uIdxHold (
      .clk(clk),
      .sys_rst(sys_rst),
      .openGate(strobeN),
      .d(holdIdxD),
      .q(holdIdxQ)
   );

   assign heldDrive = holdIdxQ[`CLH_HOLD_DRV];
   assign heldHit = holdIdxQ[`CLH_HOLD_HIT];
   assign heldMulti = holdIdxQ[`CLH_HOLD_MULTI];

   // (R14) (R15) enable gates only the chosen responder
   assign activeIndexOut = holdIdxQ[`CLH_AC_W-1:0];
   assign activeIndexOe = heldDrive & ~outEnableN;
   assign pageIndexOut = holdIdxQ[`CLH_AC_W+`CLH_PAGE_W-1:`CLH_AC_W];
   assign pageIndexOe = heldDrive & ~outEnableN;

   // (R23) chain low forces the flag low
   assign hitFlagN = ~(heldHit | ~hitChainInN);

   // (R25) open drain, pulled low only
   assign multiHitOut = 1'b0;
   assign multiHitOe = hitChainInN ? heldMulti : heldHit;

   // (R24) full flag updated after the rise of a write cycle
   always @(posedge clk) begin
      if (sys_rst) begin
         tableFullN_r <= 1'b1;
      end else if (strobeRise & ~capWriteN_r) begin
         tableFullN_r <= ~(coreAllValid & ~fullChainInN);
      end
   end
   assign tableFullN = tableFullN_r;

endmodule

/* sim/cam_lookup_host_port_test.sv */
// self-checking bench for the lookup host port
`timescale 1ns/100ps
`include "clh_defs.vh"
module cam_lookup_host_port_test;
   logic clk, sys_rst, outEnableN, hitChainInN, fullChainInN, swControl;
   logic lowestPriority, coreAllValid, coreRdValid, coreRdEntryValidN;
   logic coreResValid, coreHit, coreMulti, rdOe, rdV, cmdWrite_r;
   logic strobeN, selectOneN, selectTwoN, writeN, addrValidN, multiHitOut;
   logic wordHalfSelect, hostDataOe, entryValidIn, entryValidOut;
   logic entryValidOe, hitFlagN, tableFullN, multiHitOe, cmdValidN_r;
   logic activeIndexOe, pageIndexOe, cmdStrobe_r, cmdSelected_r;
   logic cmdIsAddr_r, cmdIsInstr_r, cmdHalf_r;
   logic [1:0] coreResKind;
   logic [3:0] pageConfig, pageIndexOut;
   logic [12:0] coreResIndex, addrCtlBus, activeIndexOut, cmdCode_r, keep;
   logic [63:0] coreRdWord, w64;
   logic [31:0] hostDataIn, hostDataOut, cmdData_r, rd, rnd;
   int err_total = 0;
   int samples_checked = 0;
   clh_host_port i_clh_host_port (.clk, .sys_rst, .strobeN, .selectOneN,
      .selectTwoN, .writeN, .addrValidN, .addrCtlBus, .wordHalfSelect,
      .outEnableN, .hostDataIn, .hostDataOut, .hostDataOe, .entryValidIn,
      .entryValidOut, .entryValidOe, .hitChainInN, .fullChainInN, .hitFlagN,
      .tableFullN, .multiHitOut, .multiHitOe, .activeIndexOut, .activeIndexOe,
      .pageIndexOut, .pageIndexOe, .swControl, .pageConfig, .lowestPriority,
      .cmdStrobe_r, .cmdWrite_r, .cmdSelected_r, .cmdIsAddr_r, .cmdIsInstr_r,
      .cmdCode_r, .cmdHalf_r, .cmdData_r, .cmdValidN_r, .coreRdValid,
      .coreRdWord, .coreRdEntryValidN, .coreResValid, .coreResKind,
      .coreResIndex, .coreHit, .coreMulti, .coreAllValid);
   clh_ctrl_model i_clh_ctrl_model (.clk, .hostDataOut, .hostDataOe,
      .entryValidOut, .entryValidOe, .strobeN, .selectOneN, .selectTwoN,
      .writeN, .addrValidN, .addrCtlBus, .wordHalfSelect, .hostDataIn,
      .entryValidIn);
   function automatic logic [63:0] wordOf(input logic [12:0] a);
      return {a, 19'h2a5a5, ~a, 19'h1c3c3};
   endfunction
   // array core stand-in: code bit 0 hits, bits 1..0 multi, bit 12 next-free
   always @(posedge clk) begin
      coreRdValid <= cmdStrobe_r && writeN;
      coreResValid <= cmdStrobe_r && !swControl;
      if (!addrValidN)
         coreResKind <= `CLH_KIND_RAND;
      else if (addrCtlBus[12])
         coreResKind <= `CLH_KIND_NFREE;
      else
         coreResKind <= `CLH_KIND_CMP;
      coreResIndex <= addrCtlBus;
      coreHit <= addrCtlBus[0];
      coreMulti <= addrCtlBus[1] && addrCtlBus[0];
      coreRdWord <= wordOf(addrCtlBus);
      coreRdEntryValidN <= addrCtlBus[2];
   end
   task automatic check(input string what, input logic [31:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic acc(input logic w, input logic [1:0] s, input logic av,
      input logic [12:0] ac, input logic hs, input logic [31:0] d);
      i_clh_ctrl_model.cycle(w, s[1], s[0], av, ac, hs, d, d[3], rd, rdOe,
         rdV);
   endtask
   task automatic summarize();
      $display("checked %0d errors %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   initial begin
      #50000;
      err_total++;
      summarize();
   end
   initial begin
      {sys_rst, outEnableN, hitChainInN, fullChainInN} = 4'hb;
      {swControl, lowestPriority, coreAllValid, pageConfig} = 7'h2a;
      {coreRdValid, coreResValid, coreHit, coreMulti} = 4'h0;
      {coreRdEntryValidN, coreResKind, coreResIndex} = 16'h0;
      coreRdWord = 64'h0;
      rnd = $urandom(32'h5c133ab4);
      repeat (16) @(posedge clk);
      #1 sys_rst = 1'b0;
      // random memory accesses, some unselected
      repeat (40) begin
         rnd = $urandom;
         w64 = wordOf(rnd[12:0]);
         acc(rnd[31], rnd[30:29], 1'b0, rnd[12:0], rnd[28], $urandom);
         if (rnd[31] && rnd[30:29] != 2'h3) begin
            check("rdata", rd, rnd[28] ? w64[63:32] : w64[31:0]);
            check("rdoe", rdOe, 1'b1);
            check("rdvalid", rdV, rnd[2]);
         end else
            check("rdoe", rdOe, 1'b0);
         check("idx", activeIndexOut, rnd[12:0]);
         check("idxoe", activeIndexOe, 1'b1);
         check("page", pageIndexOut, pageConfig);
         check("cmdwr", cmdWrite_r, !rnd[31]);
         check("cmdsel", cmdSelected_r, rnd[30:29] != 2'h3);
         check("cmdhalf", cmdHalf_r, rnd[28]);
      end
      #1 outEnableN = 1'b1;
      @(posedge clk) #1;
      check("offoe", {activeIndexOe, pageIndexOe}, 2'h0);
      check("mhout", multiHitOut, 1'b0);
      outEnableN = 1'b0;
      // compare results, chain high then low
      for (int c = 0; c < 2; c++) begin
         for (int k = 0; k < 4; k++) begin
            #1 hitChainInN = (c == 0);
            keep = {11'h05, k[1:0]};
            acc(1'b0, 2'h1, 1'b1, keep, 1'b0, 32'h0);
            check("hit", hitFlagN, !(k[0] || c));
            check("multi", multiHitOe, c ? k[0] : k == 3);
            check("cmpoe", activeIndexOe, c == 0);
            if (c == 0)
               check("cmpidx", activeIndexOut,
                  k[0] ? keep : `CLH_IDX_ONES);
         end
      end
      #1 {hitChainInN, coreAllValid, fullChainInN} = 3'h6;
      acc(1'b0, 2'h1, 1'b0, 13'h0011, 1'b0, 32'h8);
      check("full", tableFullN, 1'b0);
      #1 fullChainInN = 1'b1;
      acc(1'b0, 2'h1, 1'b0, 13'h0012, 1'b0, 32'h8);
      check("full", tableFullN, 1'b1);
      // next-free write: no drive unless chain says higher ones are full
      acc(1'b0, 2'h1, 1'b1, 13'h1000, 1'b0, 32'h8);
      check("nfoe", activeIndexOe, 1'b0);
      #1 fullChainInN = 1'b0;
      acc(1'b0, 2'h1, 1'b1, 13'h1000, 1'b0, 32'h8);
      check("nfoe", activeIndexOe, 1'b1);
      check("nfidx", activeIndexOut, `CLH_IDX_ONES);
      // software control ignores the address bus
      #1 swControl = 1'b1;
      acc(1'b0, 2'h1, 1'b1, 13'h0123, 1'b0, 32'h0abc);
      check("swcode", cmdCode_r, 13'h0abc);
      acc(1'b0, 2'h1, 1'b1, 13'h1ed0, 1'b0, 32'h0abc);
      check("swcode", cmdCode_r, 13'h0abc);
      check("instr", cmdIsInstr_r, 1'b1);
      summarize();
   end
endmodule

/* sim/clh_ctrl_model.sv */
// controller-side model that runs host strobe cycles
`timescale 1ns/100ps
module clh_ctrl_model (
   // clock
   input wire clk,
   // device outputs
   input wire [31:0] hostDataOut,
   input wire hostDataOe,
   input wire entryValidOut,
   input wire entryValidOe,
   // device inputs
   output logic strobeN,
   output logic selectOneN,
   output logic selectTwoN,
   output logic writeN,
   output logic addrValidN,
   output logic [12:0] addrCtlBus,
   output logic wordHalfSelect,
   output logic [31:0] hostDataIn,
   output logic entryValidIn
);
   logic [31:0] dq = 32'h0;
   logic vb = 1'b1;
   logic own = 1'b0;
   // released lines show the inverse, never a stale copy
   always_comb begin
      hostDataIn = (hostDataOe === 1'b1) ? hostDataOut : (own ? dq : ~dq);
      entryValidIn = (entryValidOe === 1'b1) ? entryValidOut : (own ? vb : ~vb);
   end
   initial begin
      {strobeN, selectOneN, selectTwoN, writeN} = 4'hf;
      {addrValidN, wordHalfSelect, addrCtlBus} = 15'h0;
   end
   // fields held through the low phase
   task automatic cycle(input logic w, c1, c2, av, input logic [12:0] ac,
      input logic hs, input logic [31:0] d, input logic v,
      output logic [31:0] rd, output logic rdOe, rdV);
      @(posedge clk) #1;
      {writeN, selectOneN, selectTwoN, addrValidN} = {w, c1, c2, av};
      {addrCtlBus, wordHalfSelect} = {ac, hs};
      {dq, vb, own} = {d, v, ~w};
      strobeN = 1'b0;
      repeat (6) @(posedge clk);
      #1;
      {rd, rdOe, rdV} = {hostDataOut, hostDataOe, entryValidOut};
      {strobeN, own} = 2'h2;
      repeat (3) @(posedge clk);
   endtask
endmodule

/* sim/clh_host_port_assertions.sv */
// assertion checker for the host port
`timescale 1ns/100ps
module clh_host_port_chk (
   // clock and reset
   input wire clk,
   input wire sys_rst,
   // host pins
   input wire strobeN,
   input wire selectOneN,
   input wire selectTwoN,
   input wire writeN,
   input wire addrValidN,
   input wire [12:0] addrCtlBus,
   input wire wordHalfSelect,
   input wire outEnableN,
   input wire [31:0] hostDataIn,
   input wire hostDataOe,
   input wire entryValidIn,
   input wire swControl,
   // flags and index
   input wire hitChainInN,
   input wire hitFlagN,
   input wire tableFullN,
   input wire multiHitOe,
   input wire [12:0] activeIndexOut,
   input wire activeIndexOe,
   input wire [3:0] pageIndexOut,
   input wire pageIndexOe,
   // core request
   input wire cmdStrobe_r,
   input wire cmdSelected_r,
   input wire cmdIsAddr_r,
   input wire cmdIsInstr_r,
   input wire [12:0] cmdCode_r,
   input wire cmdHalf_r,
   input wire [31:0] cmdData_r,
   input wire cmdValidN_r
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   wire sel = !(selectOneN && selectTwoN);
   a_req_after_fall: assert property (
      $fell(strobeN) |-> ##[1:2] cmdStrobe_r) else $error("no request");
   a_req_one_pulse: assert property (
      cmdStrobe_r |=> !cmdStrobe_r) else $error("request too long");
   a_capture_half: assert property (
      cmdStrobe_r |-> cmdHalf_r == wordHalfSelect && cmdSelected_r == sel)
      else $error("half or select capture");
   a_capture_write: assert property (
      cmdStrobe_r && !writeN |->
      cmdData_r == hostDataIn && cmdValidN_r == entryValidIn)
      else $error("write data capture");
   a_instr_mark: assert property (
      cmdStrobe_r |-> cmdIsInstr_r == (swControl && addrValidN))
      else $error("instruction mark");
   a_hw_address: assert property (
      cmdStrobe_r && !swControl |->
      cmdIsAddr_r == !addrValidN && cmdCode_r == addrCtlBus)
      else $error("address capture");
   a_data_drive: assert property (
      hostDataOe |-> !strobeN && writeN && sel) else $error("data drive");
   a_index_float: assert property (
      outEnableN |-> !activeIndexOe && !pageIndexOe) else $error("index oe");
   a_page_with_idx: assert property (
      pageIndexOe == activeIndexOe) else $error("page oe");
   a_index_hold: assert property (
      !strobeN |=> $stable(activeIndexOut) && $stable(pageIndexOut))
      else $error("index moved");
   a_hit_chain: assert property (
      !hitChainInN |-> !hitFlagN) else $error("hit chain");
   a_full_on_rise: assert property (
      $changed(tableFullN) |-> $past(strobeN) &&
      (!$past(strobeN, 2) || !$past(strobeN, 3))) else $error("full moved");
   a_multi_on_rise: assert property (
      $changed(multiHitOe) |-> $past(strobeN)) else $error("multi moved");
   c_read: cover property (hostDataOe);
   c_hit: cover property (!hitFlagN && hitChainInN);
   c_full: cover property (!tableFullN);
endmodule
bind clh_host_port clh_host_port_chk i_clh_host_port_chk (.clk, .sys_rst,
   .strobeN, .selectOneN, .selectTwoN, .writeN, .addrValidN, .addrCtlBus,
   .wordHalfSelect, .outEnableN, .hostDataIn, .hostDataOe, .entryValidIn,
   .swControl, .hitChainInN, .hitFlagN, .tableFullN, .multiHitOe,
   .activeIndexOut, .activeIndexOe, .pageIndexOut, .pageIndexOe,
   .cmdStrobe_r, .cmdSelected_r, .cmdIsAddr_r, .cmdIsInstr_r, .cmdCode_r,
   .cmdHalf_r, .cmdData_r, .cmdValidN_r);
